//--- panel_defines.svh
// Constants of the front-panel switch control block
`ifndef PANEL_DEFINES_SVH
`define PANEL_DEFINES_SVH

// ---------------------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------------------
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_EVENT       4'h8
`define REG_MASK        4'hC
`define ADDR_W          4

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define CTRL_INIT_DONE  0
`define CTRL_SHUTDOWN   1
`define CTRL_W          2
`define CTRL_RESET      2'h0

// ---------------------------------------------------------------------------
// Event bits
// ---------------------------------------------------------------------------
`define EV_UNLOAD       0
`define EV_FAULT_ENTER  1
`define EV_FAULT_EXIT   2
`define EV_DISK_REFUSED 3
`define EV_W            4

// ---------------------------------------------------------------------------
// Codes and timing
// ---------------------------------------------------------------------------
`define CODE_NO_ERROR   4'hF
`define CODE_W          4
`define STATUS_W        10
`define LAMPS_ALL_ON    4'hF
`define CLK_HZ          20000000
`define DEBOUNCE_MS     10
`define DEBOUNCE_CYC    ((`CLK_HZ / 1000) * `DEBOUNCE_MS)
`define FAULT_TIMEOUT_S 30
`define FAULT_TIMEOUT_CYC (`CLK_HZ * `FAULT_TIMEOUT_S)

`endif

//--- panel_pkg.sv
// Types shared by the front-panel switch control block
`default_nettype none
package panel_pkg;

    // -----------------------------------------------------------------------
    // Panel mode states, one-hot
    // -----------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_STATUS = 3'b001,
        MODE_FAULT  = 3'b010,
        MODE_UNLOAD = 3'b100
    } mode_type;

    // -----------------------------------------------------------------------
    // Classic Wishbone request
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } wb_req_type;

    // -----------------------------------------------------------------------
    // Formatter status inputs
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic       tape_busy;
        logic       tape_present;
        logic       unload_done;
        logic [3:0] status_lamps;
    } fmt_type;

endpackage : panel_pkg
`default_nettype wire

//--- switch_debounce.sv
// Synchroniser, debouncer and press detector for one panel switch
`timescale 1ns/1ps
`include "panel_defines.svh"
`default_nettype none
module switch_debounce #(
    parameter int COUNT = `DEBOUNCE_CYC
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_nrst,
    // Switch
    input  wire logic i_raw,
    output logic      o_level,
    output logic      o_press
);
    localparam int CW = $clog2(COUNT + 1);

    if (COUNT < 1) begin : g_bad_count
        $error("COUNT must be at least one");
    end

    logic          sync_a;
    logic          sync_b;
    logic [CW-1:0] count;
    wire           differs = sync_b != o_level;
    wire           settled = count == CW'(COUNT - 1);

    // -----------------------------------------------------------------------
    // Two-stage sync, stable-time filter, rising edge
    // -----------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync_a  <= 1'b0;
            sync_b  <= 1'b0;
            count   <= '0;
            o_level <= 1'b0;
            o_press <= 1'b0;
        end else begin
            sync_a  <= i_raw;
            sync_b  <= sync_a;
            count   <= (differs && !settled) ? count + CW'(1) : '0;
            o_level <= (differs && settled) ? sync_b : o_level;
            o_press <= differs && settled && sync_b;
        end
    end

endmodule : switch_debounce
`default_nettype wire

//--- panel_control.sv
// Front-panel switch control with Wishbone register access
//
// Function
// - The centre position of the mode switch causes no action.
// - A push to eject enters unload mode and winds tape to unload point.
// - Eject is ignored while host tape activity is in progress.
// - Eject is ignored when no cartridge is present.
// - A push to fault display shows a four-bit code on the four lamps.
// - Each further push shows the next code, with code F last meaning ok.
// - One push after code F returns lamps to operational status.
// - Disk guard up refuses disk writes and leaves tape writes alone.
// - Initialisation starts by itself after power-on reset.
// - The host bus interface is inactive during start-up and shutdown.
// - A timeout ends fault display; each code stays until next push or timeout.
// - Lamps show operational status unless another display is active.
`timescale 1ns/1ps
`include "panel_defines.svh"
`default_nettype none
module panel_control
    import panel_pkg::*;
#(
    parameter int DEBOUNCE = `DEBOUNCE_CYC,
    parameter int TIMEOUT  = `FAULT_TIMEOUT_CYC,
    parameter int CODES    = 16
) (
    // Clock and reset
    input  wire logic            i_sys_clk,
    input  wire logic            i_nrst,
    // Panel switches
    input  wire logic            i_sw_up,
    input  wire logic            i_sw_down,
    input  wire logic            i_disk_guard,
    // Formatter
    input  wire fmt_type         i_fmt,
    input  wire logic [CODES-1:0] i_fault_flags,
    input  wire logic            i_disk_wr_req,
    input  wire logic            i_tape_wr_req,
    // Panel lamps and actions
    output logic [3:0]           o_lamps,
    output logic                 o_tape_unload,
    output logic                 o_disk_wr_en,
    output logic                 o_tape_wr_en,
    output logic                 o_host_bus_interface_en,
    output logic                 o_init_start,
    // Wishbone slave
    input  wire wb_req_type      i_wb,
    output logic [31:0]          o_wb_dat,
    output logic                 o_wb_ack,
    output logic                 o_irq
);
    localparam int TW = $clog2(TIMEOUT + 1);

    if (CODES != 16) begin : g_bad_codes
        $error("CODES must be 16 for a four-bit code");
    end
    if (TIMEOUT < 1) begin : g_bad_timeout
        $error("TIMEOUT must be at least one");
    end

    // -----------------------------------------------------------------------
    // Switch conditioning
    // -----------------------------------------------------------------------
    logic up_press;
    logic down_press;
    logic guard_level;

    switch_debounce #(.COUNT(DEBOUNCE)) u_up (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_raw     (i_sw_up),
        .o_level   (),
        .o_press   (up_press)
    );

    switch_debounce #(.COUNT(DEBOUNCE)) u_down (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_raw     (i_sw_down),
        .o_level   (),
        .o_press   (down_press)
    );

    switch_debounce #(.COUNT(DEBOUNCE)) u_guard (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_raw     (i_disk_guard),
        .o_level   (guard_level),
        .o_press   ()
    );

    // -----------------------------------------------------------------------
    // Formatter input synchronisers
    // -----------------------------------------------------------------------
    fmt_type            fmt_a;
    fmt_type            fmt_s;
    logic [CODES-1:0]   flags_a;
    logic [CODES-1:0]   flags_s;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            fmt_a   <= '0;
            fmt_s   <= '0;
            flags_a <= '0;
            flags_s <= '0;
        end else begin
            fmt_a   <= i_fmt;
            fmt_s   <= fmt_a;
            flags_a <= i_fault_flags;
            flags_s <= flags_a;
        end
    end

    // -----------------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------------
    logic [`CTRL_W-1:0] ctrl;
    logic [`EV_W-1:0]   events;
    logic [`EV_W-1:0]   mask;
    mode_type           mode;
    logic [3:0]         code;
    logic [TW-1:0]      timer;

    // -----------------------------------------------------------------------
    // Next fault code search
    // -----------------------------------------------------------------------
    function automatic logic [3:0] next_code_of(
        input logic [3:0]       from,
        input logic [CODES-1:0] flags
    );
        logic [3:0] pick;
        logic       found;
        pick  = `CODE_NO_ERROR;
        found = 1'b0;
        for (int i = 0; i < CODES - 1; i++) begin
            if (!found && i >= int'(from) && flags[i]) begin
                pick  = 4'(i);
                found = 1'b1;
            end
        end
        return pick;
    endfunction : next_code_of

    // -----------------------------------------------------------------------
    // Mode decode
    // -----------------------------------------------------------------------
    wire in_status   = mode == MODE_STATUS;
    wire in_fault    = mode == MODE_FAULT;
    wire in_unload   = mode == MODE_UNLOAD;
    wire eject_ok    = down_press && fmt_s.tape_present
                       && !fmt_s.tape_busy;
    wire timer_done  = timer == TW'(TIMEOUT - 1);
    wire fault_step  = in_fault && up_press;
    wire fault_leave = fault_step && code == `CODE_NO_ERROR;
    wire fault_tmo   = in_fault && !up_press && timer_done;
    wire fault_enter = in_status && up_press;
    wire unload_go   = in_status && eject_ok;
    wire unload_end  = in_unload && (fmt_s.unload_done || fmt_s.tape_busy
                       || !fmt_s.tape_present);
    wire [3:0] first_code = next_code_of(4'h0, flags_s);
    wire [3:0] step_code  = next_code_of(code + 4'h1, flags_s);

    mode_type next_mode;
    always_comb begin
        next_mode = mode;
        unique case (mode)
            MODE_STATUS: begin
                if (fault_enter) begin
                    next_mode = MODE_FAULT;
                end else if (unload_go) begin
                    next_mode = MODE_UNLOAD;
                end
            end
            MODE_FAULT: begin
                if (fault_leave || fault_tmo) begin
                    next_mode = MODE_STATUS;
                end
            end
            MODE_UNLOAD: begin
                if (unload_end) begin
                    next_mode = MODE_STATUS;
                end
            end
            default: next_mode = MODE_STATUS;
        endcase
    end

    wire [3:0] next_code = fault_enter ? first_code
                         : (fault_step ? step_code : code);
    wire [TW-1:0] next_timer = (!in_fault || up_press) ? '0
                             : (timer_done ? timer : timer + TW'(1));

    // -----------------------------------------------------------------------
    // Write protection and host gating
    // -----------------------------------------------------------------------
    wire host_ok = ctrl[`CTRL_INIT_DONE] && !ctrl[`CTRL_SHUTDOWN];
    wire disk_refused = i_disk_wr_req && guard_level;

    wire [3:0] next_lamps = in_fault ? code : fmt_s.status_lamps;

    // -----------------------------------------------------------------------
    // Bus decode
    // -----------------------------------------------------------------------
    wire bus_req   = i_wb.cyc && i_wb.stb && !o_wb_ack;
    wire bus_wr    = bus_req && i_wb.we && i_wb.sel[0];
    wire wr_ctrl   = bus_wr && i_wb.adr == `REG_CTRL;
    wire wr_mask   = bus_wr && i_wb.adr == `REG_MASK;
    wire rd_event  = bus_req && !i_wb.we && i_wb.adr == `REG_EVENT;
    wire [`EV_W-1:0] new_events = {disk_refused, fault_leave || fault_tmo,
                                   fault_enter, unload_go};
    wire [`EV_W-1:0] next_events = (rd_event ? '0 : events) | new_events;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (i_wb.adr)
            `REG_CTRL:   rd_mux[`CTRL_W-1:0] = ctrl;
            `REG_STATUS: rd_mux[`STATUS_W-1:0] = {fmt_s.tape_present,
                                        fmt_s.tape_busy,
                                        guard_level, code, mode};
            `REG_EVENT:  rd_mux[`EV_W-1:0] = events;
            `REG_MASK:   rd_mux[`EV_W-1:0] = mask;
            default:     rd_mux = 32'h0000_0000;
        endcase
    end

    // -----------------------------------------------------------------------
    // State and register update
    // -----------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mode <= MODE_STATUS;
        end else begin
            mode <= next_mode;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            code <= `CODE_NO_ERROR;
        end else begin
            code <= next_code;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            timer <= '0;
        end else begin
            timer <= next_timer;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl <= `CTRL_RESET;
        end else begin
            ctrl <= wr_ctrl ? i_wb.dat[`CTRL_W-1:0] : ctrl;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mask <= '0;
        end else begin
            mask <= wr_mask ? i_wb.dat[`EV_W-1:0] : mask;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            events <= '0;
        end else begin
            events <= next_events;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= bus_req;
            o_wb_dat <= bus_req ? rd_mux : o_wb_dat;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(next_events & mask);
        end
    end

    // -----------------------------------------------------------------------
    // Panel and gating outputs
    // -----------------------------------------------------------------------
    logic init_seen;

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_lamps <= `LAMPS_ALL_ON;
        end else begin
            o_lamps <= next_lamps;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_tape_unload <= 1'b0;
        end else begin
            o_tape_unload <= next_mode == MODE_UNLOAD;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_disk_wr_en <= 1'b0;
        end else begin
            o_disk_wr_en <= i_disk_wr_req && !guard_level;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_tape_wr_en <= 1'b0;
        end else begin
            o_tape_wr_en <= i_tape_wr_req;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_host_bus_interface_en <= 1'b0;
        end else begin
            o_host_bus_interface_en <= host_ok;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_init_start <= 1'b0;
            init_seen    <= 1'b0;
        end else begin
            o_init_start <= !init_seen;
            init_seen    <= 1'b1;
        end
    end

endmodule : panel_control
`default_nettype wire

//--- panel_control_chk.sv
// Concurrent checks on the ports of the front-panel switch control block
`timescale 1ns/1ps
`include "panel_defines.svh"
`default_nettype none
module panel_control_chk
    import panel_pkg::*;
#(
    parameter int DEBOUNCE = 4,
    parameter int TIMEOUT  = 50,
    parameter int CODES    = 16
) (
    // Clock, reset and panel
    input wire logic             i_sys_clk, i_nrst, i_sw_up, i_sw_down,
    input wire logic             i_disk_guard, i_disk_wr_req, i_tape_wr_req,
    // Formatter and bus
    input wire fmt_type          i_fmt,
    input wire logic [CODES-1:0] i_fault_flags,
    input wire wb_req_type       i_wb,
    // Watched outputs
    input wire logic [3:0]       o_lamps,
    input wire logic [31:0]      o_wb_dat,
    input wire logic             o_tape_unload, o_disk_wr_en, o_tape_wr_en,
    input wire logic             o_host_bus_interface_en, o_init_start,
    input wire logic             o_wb_ack, o_irq
);
    localparam int LIM = TIMEOUT + DEBOUNCE + 12;
    int idle;
    wire logic take = i_wb.cyc && i_wb.stb && !o_wb_ack;
    wire logic wr_ctrl = take && i_wb.we && i_wb.sel[0]
                         && (i_wb.adr == `REG_CTRL);

    // Cycles since the mode switch last returned to centre
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) idle <= 0;
        else if (i_sw_up || i_sw_down) idle <= 0;
        else if (idle < LIM) idle <= idle + 1;
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    ack_follows_a: assert property (take |=> o_wb_ack)
        else $error("bus request not acknowledged");
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    init_pulse_a: assert property (o_init_start |=> !o_init_start)
        else $error("init start longer than one cycle");
    host_off_a: assert property (wr_ctrl && i_wb.dat[1]
        |-> ##[1:2] !o_host_bus_interface_en)
        else $error("host interface still enabled at shutdown");
    host_on_a: assert property ($rose(o_host_bus_interface_en)
        |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
        else $error("host interface enabled without control write");
    guard_block_a: assert property (i_disk_guard [*8] ##1
        i_disk_guard [*4] |=> !o_disk_wr_en)
        else $error("disk write passed while guarded");
    disk_req_a: assert property (o_disk_wr_en |-> $past(i_disk_wr_req))
        else $error("disk write enable without request");
    tape_wr_a: assert property (o_tape_wr_en == $past(i_tape_wr_req))
        else $error("tape write enable not following request");
    no_tape_a: assert property (!i_fmt.tape_present [*6]
        |-> !o_tape_unload)
        else $error("unload active without cartridge");
    tape_busy_a: assert property (i_fmt.tape_busy [*6]
        |-> !o_tape_unload)
        else $error("unload active during tape activity");
    idle_status_a: assert property (
        ($stable(i_fmt.status_lamps) [*4] ##0 idle == LIM)
        |-> o_lamps == i_fmt.status_lamps)
        else $error("lamps not showing status when idle");
endmodule : panel_control_chk
`default_nettype wire

//--- panel_operator.sv
// Operator model: bouncing presses of the panel mode switch
`timescale 1ns/1ps
`default_nettype none
module panel_operator (
    // Clock
    input  wire logic i_sys_clk,
    // Switch contacts
    output var logic  o_up,
    output var logic  o_down
);
    logic v;
    initial begin
        o_up = 1'b0;
        o_down = 1'b0;
    end
    // One press: bounce, steady contact, bounce, rest at centre
    task automatic press(input logic dn);
        for (int k = 0; k < 30; k++) begin
            @(posedge i_sys_clk);
            v = (k < 4) ? !k[0] : (k < 16) ? 1'b1 : (k < 19) && k[0];
            o_up <= v && !dn;
            o_down <= v && dn;
        end
    endtask : press
endmodule : panel_operator
`default_nettype wire

//--- test_front_panel_switch_control.sv
// Self-checking bench for the front-panel switch control block
`timescale 1ns/1ps
`include "panel_defines.svh"
`default_nettype none
module test_front_panel_switch_control;
    import panel_pkg::*;
    localparam int TMO = 50;
    logic        i_sys_clk, i_nrst, i_disk_guard;
    logic        i_disk_wr_req, i_tape_wr_req;
    wire logic   i_sw_up, i_sw_down;
    fmt_type     i_fmt;
    logic [15:0] i_fault_flags, flags;
    wb_req_type  i_wb;
    logic [31:0] o_wb_dat, rd;
    logic [3:0]  o_lamps;
    logic        o_tape_unload, o_disk_wr_en, o_tape_wr_en, o_irq;
    logic        o_host_bus_interface_en, o_init_start, o_wb_ack;
    logic [2:0]  ej [3];
    logic [1:0]  cv;
    int          err_total, checks, seed;
    int          q[$];

    panel_control #(.DEBOUNCE(4), .TIMEOUT(TMO)) u_panel_control (
        .i_sys_clk, .i_nrst, .i_sw_up, .i_sw_down, .i_disk_guard, .i_fmt,
        .i_fault_flags, .i_disk_wr_req, .i_tape_wr_req, .o_lamps,
        .o_tape_unload, .o_disk_wr_en, .o_tape_wr_en,
        .o_host_bus_interface_en, .o_init_start, .i_wb, .o_wb_dat,
        .o_wb_ack, .o_irq);
    panel_operator u_panel_operator (
        .i_sys_clk, .o_up(i_sw_up), .o_down(i_sw_down));

    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    task automatic close_out;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic cmp(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask : cmp

    // Classic single Wishbone cycle, entered at a rising edge
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        i_wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
        do begin
            @(posedge i_sys_clk);
        end while (o_wb_ack !== 1'b1);
        rd = o_wb_dat;
        i_wb <= '0;
        @(posedge i_sys_clk);
    endtask : wb

    task automatic ev(input logic [31:0] e);
        cmp("irq", 1, o_irq);
        wb(1'b0, `REG_EVENT, 0);
        cmp("event", e, rd);
        repeat (2) @(posedge i_sys_clk);
        cmp("irq", 0, o_irq);
    endtask : ev

    task automatic fault_run(input logic tmo);
        flags = 16'($random(seed));
        flags[15] = 1'b0;
        i_fault_flags <= flags;
        i_fmt.status_lamps <= 4'($random(seed));
        q = {};
        for (int i = 0; i < 15; i++) if (flags[i]) q.push_back(i);
        q.push_back(15);
        if (tmo) q = q[0:0];
        foreach (q[i]) begin
            u_panel_operator.press(1'b0);
            cmp("lamps", 32'(q[i]), o_lamps);
        end
        if (tmo) repeat (TMO + 20) @(posedge i_sys_clk);
        else u_panel_operator.press(1'b0);
        cmp("lamps", 32'(i_fmt.status_lamps), o_lamps);
        ev(32'h6);
    endtask : fault_run

    initial begin
        seed = 80;
        err_total = 0;
        checks = 0;
        ej = '{3'b000, 3'b110, 3'b101};
        i_nrst = 1'b0;
        i_disk_guard = 1'b0;
        i_disk_wr_req = 1'b0;
        i_tape_wr_req = 1'b0;
        i_fmt = '0;
        i_fault_flags = '0;
        i_wb = '0;
        repeat (6) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        cmp("init_start", 1, o_init_start);
        @(posedge i_sys_clk);
        cmp("init_start", 0, o_init_start);
        cmp("host_if_en", 0, o_host_bus_interface_en);
        wb(1'b1, `REG_MASK, 32'hF);
        wb(1'b0, `REG_MASK, 0);
        cmp("mask", 32'hF, rd);
        wb(1'b0, 4'h2, 0);
        cmp("unmapped", 0, rd);
        wb(1'b0, `REG_STATUS, 0);
        cmp("status", 32'h79, rd);
        for (int i = 0; i < 3; i++) begin
            cv = (i == 1) ? 2'h3 : 2'h1;
            wb(1'b1, `REG_CTRL, {30'h0, cv});
            repeat (2) @(posedge i_sys_clk);
            cmp("host_if_en", cv == 2'h1, o_host_bus_interface_en);
        end
        fault_run(1'b0);
        fault_run(1'b1);
        for (int i = 0; i < 3; i++) begin
            i_fmt.tape_present <= ej[i][2];
            i_fmt.tape_busy <= ej[i][1];
            repeat (8) @(posedge i_sys_clk);
            u_panel_operator.press(1'b1);
            cmp("unload", ej[i][0], o_tape_unload);
        end
        i_fmt.unload_done <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        cmp("unload", 0, o_tape_unload);
        i_fmt.unload_done <= 1'b0;
        ev(32'h1);
        i_disk_guard <= 1'b1;
        i_disk_wr_req <= 1'b1;
        i_tape_wr_req <= 1'b1;
        repeat (14) @(posedge i_sys_clk);
        cmp("disk_wr_en", 0, o_disk_wr_en);
        cmp("tape_wr_en", 1, o_tape_wr_en);
        i_disk_guard <= 1'b0;
        repeat (14) @(posedge i_sys_clk);
        cmp("disk_wr_en", 1, o_disk_wr_en);
        i_disk_wr_req <= 1'b0;
        i_tape_wr_req <= 1'b0;
        ev(32'h8);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge i_sys_clk);
        err_total++;
        close_out();
    end
endmodule : test_front_panel_switch_control

bind panel_control panel_control_chk #(
    .DEBOUNCE(DEBOUNCE), .TIMEOUT(TIMEOUT), .CODES(CODES)
) u_panel_control_chk (
    .i_sys_clk, .i_nrst, .i_sw_up, .i_sw_down, .i_disk_guard,
    .i_disk_wr_req, .i_tape_wr_req, .i_fmt, .i_fault_flags, .i_wb,
    .o_lamps, .o_wb_dat, .o_tape_unload, .o_disk_wr_en, .o_tape_wr_en,
    .o_host_bus_interface_en, .o_init_start, .o_wb_ack, .o_irq);
`default_nettype wire
